// ### hdl/pcc_pkg.sv
// Purpose: Constants and types for the PLL clock control registers.
// Assumes: 8-bit registers behind a plain strobe port.
// Notes:   Register indices and single-bit field positions live here; programming nibbles are sliced in pcc_pll_regs.
//
// Operation
// RL1: Lock interrupt enable writable only in automatic mode; otherwise reads 0; reset clears.
// RL2: In automatic mode every lock indicator change sets the flag; flag and enable raise interrupt.
// RL3: Lock-change flag reads 0 while automatic bandwidth mode is off.
// RL4: A read of the control register clears the flag, except in break without flag-clear enable; reset clears it.
// RL5: PLL-on cannot clear while VCO clock selected; reset sets it.
// RL6: Base select picks crystal or VCO; output runs at half that rate.
// RL7: Base select cannot set while PLL-on is 0; two writes needed.
// RL8: Source switch waits three edges of each clock, output frozen meanwhile; VCO edges are not awaited while the VCO is off.
// RL9: Reset and stop clear the base clock select bit.
// RL10: Low four control bits always read ones and ignore writes.
// RL11: Bandwidth mode bit: 1 automatic, 0 manual; read/write; reset manual.
// RL12: Software clears tracking bit before turning PLL on in manual mode.
// RL13: Lock bit reads live lock in automatic mode, 0 in manual; reset clears.
// RL14: Tracking bit is status in automatic mode, forcing control in manual.
// RL15: Manual tracking value kept hidden during automatic mode; reset clears.
// RL16: Software writes 1 to crystal-loss bit, waits N*4 cycles, reads it.
// RL17: Crystal-loss bit works only with VCO selected, else reads 0.
// RL18: Software writes zeros to the low four bandwidth test bits.
// RL19: Multiplier nibble gives N, with 0 taken as 1; reset loads 6.
// RL20: Multiplier writes ignored while PLL-on is 1.
// RL21: Range nibble locked while PLL on; zero disables PLL, blocks VCO select.
// RL22: Range nibble resets to 6.
// RL23: Interrupt output comes from lock path through flag and enable.
// RL24: Break state without flag-clear enable leaves the flag untouched.
// RL25: Lock indicator synchronised; change between samples sets the flag.

package pcc_pkg;
   // ===========================================================
   // Register map (byte indices)
   localparam logic [1:0] PCC_IDX_CTRL  = 2'h0;
   localparam logic [1:0] PCC_IDX_BW    = 2'h1;
   localparam logic [1:0] PCC_IDX_PROG  = 2'h2;
   // ===========================================================
   // Control register fields
   localparam int         PCC_CTRL_IE   = 7;
   localparam int         PCC_CTRL_FLAG = 6;
   localparam int         PCC_CTRL_ON   = 5;
   localparam int         PCC_CTRL_BCS  = 4;
   localparam logic [3:0] PCC_CTRL_LOW  = 4'hf;
   // ===========================================================
   // Bandwidth register fields
   localparam int         PCC_BW_AUTO   = 7;
   localparam int         PCC_BW_LOCK   = 6;
   localparam int         PCC_BW_TRACK  = 5;
   localparam int         PCC_BW_XLD    = 4;
   // ===========================================================
   // Programming register reset values and nibble constants
   localparam logic [3:0] PCC_MUL_RST   = 4'h6;
   localparam logic [3:0] PCC_VRS_RST   = 4'h6;
   localparam logic [3:0] PCC_NIB_ZERO  = 4'h0;
   localparam logic [3:0] PCC_NIB_ONE   = 4'h1;
   // ===========================================================
   // Clock switch
   localparam logic [1:0] PCC_SW_EDGES  = 2'h3;
   typedef enum logic {PCC_SW_RUN = 1'b0, PCC_SW_FREEZE = 1'b1} pcc_sw_state_t;
endpackage : pcc_pkg

// ### hdl/pcc_clk_if.sv
// Purpose: Carrier between register logic and base clock switch.
// Assumes: Single clock domain.
// Notes:   Control side drives select and VCO run.
`timescale 1ns/1ps
`default_nettype none
interface pcc_clk_if;
   logic select_vco;   // Requested source, 1 = VCO
   logic vco_run;      // VCO enabled
   logic frozen;       // Switch in progress
   logic clk_out;      // Divided base clock
   modport ctrl (output select_vco, output vco_run, input frozen, input clk_out);
   modport sw   (input select_vco, input vco_run, output frozen, output clk_out);
endinterface : pcc_clk_if
`default_nettype wire

// ### hdl/pcc_lock_sync.sv
// Purpose: Synchronise the lock indicator and detect its changes.
// Assumes: Lock detector output may be asynchronous.
// Notes:   Change pulse is one cycle, from a flop.
`timescale 1ns/1ps
`default_nettype none
module pcc_lock_sync (
   input  wire logic clk,        // System clock
   input  wire logic sys_rst,    // Sync reset, high
   input  wire logic lock_in,    // Raw lock indicator
   output var  logic lock_level, // Synchronised lock
   output var  logic lock_chg    // One-cycle change pulse
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // Only sync_r reads meta_r
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= lock_in;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_r   <= 1'b0;
         lock_chg <= 1'b0;
      end else begin
         prev_r   <= sync_r;
         lock_chg <= sync_r ^ prev_r;  // [RL25]
      end
   end

   assign lock_level = prev_r;
endmodule : pcc_lock_sync
`default_nettype wire

// ### hdl/pcc_clk_switch.sv
// Purpose: Base clock selector with freeze during source change.
// Assumes: Source clocks sampled as levels; both far below clk rate.
// Notes:   Output toggles on each sampled rising edge of the source.
`timescale 1ns/1ps
`default_nettype none
module pcc_clk_switch (
   input  wire logic clk,           // System clock
   input  wire logic sys_rst,       // Sync reset, high
   input  wire logic crystal_clock, // Crystal clock level
   input  wire logic vco_clock,     // VCO clock level
   pcc_clk_if.sw     cif            // Control carrier
);
   pcc_pkg::pcc_sw_state_t state_r;
   logic       xtal_q_r;
   logic       vco_q_r;
   logic       src_r;
   logic       out_r;
   logic [1:0] xcnt_r;
   logic [1:0] vcnt_r;
   logic       xtal_edge;
   logic       vco_edge;
   logic       src_edge;
   logic       done;

   assign xtal_edge = crystal_clock & ~xtal_q_r;
   assign vco_edge  = vco_clock & ~vco_q_r;
   assign src_edge  = src_r ? vco_edge : xtal_edge;
   // A stopped VCO would otherwise hang the switch
   assign done      = (xcnt_r == pcc_pkg::PCC_SW_EDGES) &&
                      ((vcnt_r == pcc_pkg::PCC_SW_EDGES) || !cif.vco_run);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xtal_q_r <= 1'b0;
         vco_q_r  <= 1'b0;
      end else begin
         xtal_q_r <= crystal_clock;
         vco_q_r  <= vco_clock;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= pcc_pkg::PCC_SW_RUN;
         src_r   <= 1'b0;
         xcnt_r  <= 2'h0;
         vcnt_r  <= 2'h0;
      end else begin
         unique case (state_r)
            pcc_pkg::PCC_SW_RUN: begin
               xcnt_r <= 2'h0;
               vcnt_r <= 2'h0;
               if (cif.select_vco != src_r) begin
                  state_r <= pcc_pkg::PCC_SW_FREEZE;  // [RL8]
               end
            end
            pcc_pkg::PCC_SW_FREEZE: begin
               if (xtal_edge && xcnt_r != pcc_pkg::PCC_SW_EDGES) begin
                  xcnt_r <= xcnt_r + 2'h1;
               end
               if (vco_edge && vcnt_r != pcc_pkg::PCC_SW_EDGES) begin
                  vcnt_r <= vcnt_r + 2'h1;
               end
               if (done) begin
                  src_r   <= cif.select_vco;  // [RL8]
                  state_r <= pcc_pkg::PCC_SW_RUN;
               end
            end
         endcase
      end
   end

   // Halving gives the documented 50% duty cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_r <= 1'b0;
      end else if (state_r == pcc_pkg::PCC_SW_RUN && src_edge) begin
         out_r <= ~out_r;  // [RL6]
      end
   end

   assign cif.clk_out = out_r;
   assign cif.frozen  = (state_r == pcc_pkg::PCC_SW_FREEZE);

   property p_freeze_hold;
      @(posedge clk) disable iff (sys_rst)
      (state_r == pcc_pkg::PCC_SW_FREEZE) |=> $stable(out_r);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("clock moved while frozen"); // [RL8]
endmodule : pcc_clk_switch
`default_nettype wire

// ### hdl/pcc_pll_regs.sv
// Purpose: PLL control, bandwidth and programming registers.
// Assumes: Inputs synchronous to clk except lock_status.
// Notes:   Read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps
`default_nettype none
module pcc_pll_regs (
   input  wire logic       clk,                     // 25 MHz system clock
   input  wire logic       sys_rst,                 // Sync reset, high
   input  wire logic [1:0] reg_addr,                // Register index
   input  wire logic [7:0] reg_wdata,               // Write data
   input  wire logic       reg_wr,                  // Write strobe
   input  wire logic       reg_rd,                  // Read strobe
   output logic      [7:0] reg_rdata,               // Read data, next cycle
   input  wire logic       crystal_clock,           // Crystal clock level
   input  wire logic       vco_clock,               // VCO clock level
   input  wire logic       lock_status,             // Lock detector
   input  wire logic       track_status,            // Auto tracking indication
   input  wire logic       stop_req,                // Stop instruction pulse
   input  wire logic       break_state,             // Break active
   input  wire logic       break_flag_clear_enable, // Break may clear flags
   output logic            base_clock_out,          // Divided base clock
   output logic            pll_cpu_interrupt,       // Interrupt request
   output logic            pll_enable,              // PLL and VCO enable
   output logic            auto_bandwidth,          // Automatic mode
   output logic            manual_track,            // Forced tracking mode
   output logic      [3:0] feedback_multiplier,     // Effective N
   output logic      [3:0] vco_range_multiplier,    // L nibble
   output logic            clock_switching          // Source change running
);
   // ===========================================================
   // Decode
   function automatic logic reg_hit(input logic [1:0] a, input logic [1:0] idx);
      reg_hit = (a == idx);
   endfunction : reg_hit

   function automatic logic [3:0] eff_mul(input logic [3:0] m);
      eff_mul = (m == pcc_pkg::PCC_NIB_ZERO) ? pcc_pkg::PCC_NIB_ONE : m;
   endfunction : eff_mul

   logic       wr_ctrl;
   logic       wr_bw;
   logic       wr_prog;
   logic       rd_ctrl;
   logic       break_protect;
   logic       lock_level;
   logic       lock_chg;
   logic       ie_r;
   logic       flag_r;
   logic       on_r;
   logic       bcs_r;
   logic       auto_r;
   logic       lock_r;
   logic       track_stat_r;
   logic       manual_acq_r;
   logic       xld_r;
   logic       xtal_q_r;
   logic [3:0] mul_r;
   logic [3:0] vrs_r;
   logic       irq_r;
   logic [7:0] rdata_r;
   logic [7:0] ctrl_view;
   logic [7:0] bw_view;
   logic       vrs_zero;

   assign wr_ctrl       = reg_wr && reg_hit(reg_addr, pcc_pkg::PCC_IDX_CTRL);
   assign wr_bw         = reg_wr && reg_hit(reg_addr, pcc_pkg::PCC_IDX_BW);
   assign wr_prog       = reg_wr && reg_hit(reg_addr, pcc_pkg::PCC_IDX_PROG);
   assign rd_ctrl       = reg_rd && reg_hit(reg_addr, pcc_pkg::PCC_IDX_CTRL);
   assign break_protect = break_state && !break_flag_clear_enable;
   assign vrs_zero      = (vrs_r == pcc_pkg::PCC_NIB_ZERO);

   pcc_clk_if cif ();

   pcc_lock_sync u_lock (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .lock_in    (lock_status),
      .lock_level (lock_level),
      .lock_chg   (lock_chg)
   );

   pcc_clk_switch u_switch (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .crystal_clock (crystal_clock),
      .vco_clock     (vco_clock),
      .cif           (cif)
   );

   assign cif.select_vco = bcs_r;   // [RL6]
   assign cif.vco_run    = pll_enable;

   // ===========================================================
   // Bandwidth mode and lock status
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         auto_r <= 1'b0;
      end else if (wr_bw) begin
         auto_r <= reg_wdata[pcc_pkg::PCC_BW_AUTO];  // [RL11]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_r       <= 1'b0;
         track_stat_r <= 1'b0;
      end else begin
         lock_r       <= auto_r && lock_level;  // [RL13]
         track_stat_r <= track_status;
      end
   end

   // Hidden manual value survives automatic periods
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         manual_acq_r <= 1'b0;  // [RL15]
      end else if (wr_bw && !auto_r) begin
         manual_acq_r <= reg_wdata[pcc_pkg::PCC_BW_TRACK];  // [RL14]
      end
   end

   // ===========================================================
   // Interrupt enable, flag and request
   always_ff @(posedge clk) begin
      if (sys_rst || !auto_r) begin
         ie_r <= 1'b0;  // [RL1]
      end else if (wr_ctrl) begin
         ie_r <= reg_wdata[pcc_pkg::PCC_CTRL_IE];  // [RL1]
      end
   end

   // Set beats the read clear so no lock change is lost
   always_ff @(posedge clk) begin
      if (sys_rst || !auto_r) begin
         flag_r <= 1'b0;  // [RL3]
      end else if (lock_chg) begin
         flag_r <= 1'b1;  // [RL2] [RL25]
      end else if (rd_ctrl && !break_protect) begin
         flag_r <= 1'b0;  // [RL4] [RL24]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_r && ie_r && auto_r;  // [RL2] [RL23]
      end
   end

   // ===========================================================
   // PLL on and base clock select
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         on_r <= 1'b1;  // [RL5]
      end else if (wr_ctrl && !(bcs_r && !reg_wdata[pcc_pkg::PCC_CTRL_ON])) begin
         on_r <= reg_wdata[pcc_pkg::PCC_CTRL_ON];  // [RL5]
      end
   end

   // Old PLL-on value gates the set, so one write cannot do both
   always_ff @(posedge clk) begin
      if (sys_rst || stop_req || vrs_zero) begin
         bcs_r <= 1'b0;  // [RL9] [RL21]
      end else if (wr_ctrl) begin
         bcs_r <= reg_wdata[pcc_pkg::PCC_CTRL_BCS] && on_r;  // [RL7]
      end
   end

   // ===========================================================
   // Crystal loss check: any rising crystal edge after arming clears it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xtal_q_r <= 1'b0;
      end else begin
         xtal_q_r <= crystal_clock;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !bcs_r) begin
         xld_r <= 1'b0;  // [RL17]
      end else if (wr_bw && reg_wdata[pcc_pkg::PCC_BW_XLD]) begin
         xld_r <= 1'b1;  // [RL16]
      end else if (crystal_clock && !xtal_q_r) begin
         xld_r <= 1'b0;  // [RL16]
      end
   end

   // ===========================================================
   // Programming register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mul_r <= pcc_pkg::PCC_MUL_RST;  // [RL19]
         vrs_r <= pcc_pkg::PCC_VRS_RST;  // [RL22]
      end else if (wr_prog && !on_r) begin
         mul_r <= reg_wdata[7:4];  // [RL20]
         vrs_r <= reg_wdata[3:0];  // [RL21]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_enable           <= 1'b1;
         auto_bandwidth       <= 1'b0;
         manual_track         <= 1'b0;
         feedback_multiplier  <= eff_mul(pcc_pkg::PCC_MUL_RST);
         vco_range_multiplier <= pcc_pkg::PCC_VRS_RST;
         clock_switching      <= 1'b0;
         base_clock_out       <= 1'b0;
      end else begin
         pll_enable           <= on_r && !vrs_zero;  // [RL21]
         auto_bandwidth       <= auto_r;
         manual_track         <= !auto_r && manual_acq_r;  // [RL14]
         feedback_multiplier  <= eff_mul(mul_r);  // [RL19]
         vco_range_multiplier <= vrs_r;
         clock_switching      <= cif.frozen;
         base_clock_out       <= cif.clk_out;
      end
   end

   // ===========================================================
   // Read path
   always_comb begin
      ctrl_view = {ie_r, flag_r && auto_r, on_r, bcs_r, pcc_pkg::PCC_CTRL_LOW};  // [RL10]
      bw_view   = {auto_r, lock_r, auto_r ? track_stat_r : manual_acq_r,
                   xld_r && bcs_r, 4'h0};  // [RL17]
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !reg_rd) begin
         rdata_r <= 8'h00;
      end else begin
         unique case (reg_addr)
            pcc_pkg::PCC_IDX_CTRL: rdata_r <= ctrl_view;
            pcc_pkg::PCC_IDX_BW:   rdata_r <= bw_view;
            pcc_pkg::PCC_IDX_PROG: rdata_r <= {mul_r, vrs_r};
            default:               rdata_r <= 8'h00;
         endcase
      end
   end

   assign reg_rdata         = rdata_r;
   assign pll_cpu_interrupt = irq_r;

   // ===========================================================
   // Checks
   property p_ie_manual;
      @(posedge clk) disable iff (sys_rst)
      (wr_ctrl && !auto_r) |=> !ie_r;
   endproperty
   a_ie_manual: assert property (p_ie_manual) else $error("enable written in manual mode"); // [RL1]

   property p_flag_set;
      @(posedge clk) disable iff (sys_rst)
      (auto_r && lock_chg) |=> flag_r ##1 irq_r == ($past(ie_r) && $past(auto_r));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("lock change lost"); // [RL2]

   property p_flag_manual;
      @(posedge clk) disable iff (sys_rst)
      !auto_r |=> !flag_r ##1 !irq_r;
   endproperty
   a_flag_manual: assert property (p_flag_manual) else $error("flag set in manual mode"); // [RL3]

   property p_flag_read;
      @(posedge clk) disable iff (sys_rst)
      (rd_ctrl && !break_protect && !lock_chg) |=> !flag_r;
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("read did not clear flag"); // [RL4]

   property p_break_keep;
      @(posedge clk) disable iff (sys_rst)
      (rd_ctrl && break_protect && flag_r && auto_r) |=> flag_r;
   endproperty
   a_break_keep: assert property (p_break_keep) else $error("flag cleared in break"); // [RL24]

   property p_on_hold;
      @(posedge clk) disable iff (sys_rst)
      (wr_ctrl && bcs_r && !reg_wdata[pcc_pkg::PCC_CTRL_ON]) |=> on_r;
   endproperty
   a_on_hold: assert property (p_on_hold) else $error("PLL turned off while selected"); // [RL5]

   property p_bcs_block;
      @(posedge clk) disable iff (sys_rst)
      (wr_ctrl && !on_r) |=> !bcs_r;
   endproperty
   a_bcs_block: assert property (p_bcs_block) else $error("select set with PLL off"); // [RL7]

   property p_stop_clear;
      @(posedge clk) disable iff (sys_rst)
      stop_req |=> !bcs_r;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop left select set"); // [RL9]

   property p_low_ones;
      @(posedge clk) disable iff (sys_rst)
      rd_ctrl |=> reg_rdata[3:0] == pcc_pkg::PCC_CTRL_LOW;
   endproperty
   a_low_ones: assert property (p_low_ones) else $error("unimplemented bits not ones"); // [RL10]

   property p_lock_manual;
      @(posedge clk) disable iff (sys_rst)
      !auto_r |=> !lock_r;
   endproperty
   a_lock_manual: assert property (p_lock_manual) else $error("lock set in manual mode"); // [RL13]

   property p_mul_prot;
      @(posedge clk) disable iff (sys_rst)
      (wr_prog && on_r) |=> $stable(mul_r) && $stable(vrs_r);
   endproperty
   a_mul_prot: assert property (p_mul_prot) else $error("programming written while on"); // [RL20]

   property p_vrs_zero;
      @(posedge clk) disable iff (sys_rst)
      vrs_zero |=> !bcs_r ##1 !pll_enable;
   endproperty
   a_vrs_zero: assert property (p_vrs_zero) else $error("zero range left PLL usable"); // [RL21]
endmodule : pcc_pll_regs
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for the PLL clock control registers.
// Assumes: Strobe bus with read data one cycle after the read strobe.
// Notes:   Reads queue their expectation; a monitor pops it one cycle later.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0]  reg_addr = 2'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        crystal_clock = 1'b0, vco_clock = 1'b0, lock_status = 1'b0;
   logic        track_status = 1'b0, stop_req = 1'b0, break_state = 1'b0;
   logic        break_flag_clear_enable = 1'b0;
   logic        xtal_run = 1'b1, rd_q = 1'b0, hold;
   wire  [7:0]  reg_rdata;
   wire  [3:0]  feedback_multiplier, vco_range_multiplier;
   wire         base_clock_out, pll_cpu_interrupt, pll_enable;
   wire         auto_bandwidth, manual_track, clock_switching;
   logic [7:0]  exp_q[$];
   logic [31:0] seed = 32'h160b;
   int          err_count = 0, cmp_count = 0, n;

   pcc_pll_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock), .lock_status(lock_status),
      .track_status(track_status), .stop_req(stop_req), .break_state(break_state),
      .break_flag_clear_enable(break_flag_clear_enable), .base_clock_out(base_clock_out),
      .pll_cpu_interrupt(pll_cpu_interrupt), .pll_enable(pll_enable),
      .auto_bandwidth(auto_bandwidth), .manual_track(manual_track),
      .feedback_multiplier(feedback_multiplier),
      .vco_range_multiplier(vco_range_multiplier), .clock_switching(clock_switching));

   // ===========================================================
   // Clocks; source clocks far slower than clk so the sampler sees each edge
   always #20 clk = ~clk;
   always begin
      repeat (3) @(posedge clk);
      if (xtal_run) crystal_clock <= ~crystal_clock;
   end
   always begin
      repeat (2) @(posedge clk);
      vco_clock <= ~vco_clock;
   end

   // ===========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask : rd

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // ===========================================================
   // Read data monitor
   always @(posedge clk) begin
      if (rd_q) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=none", $time, reg_rdata);
         end else chk(reg_rdata, exp_q.pop_front());
      end
      rd_q <= reg_rd;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude();
   end

   // ===========================================================
   // Tests
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(0, 8'h2f);
      rd(1, 8'h00);
      rd(2, 8'h66);
      rd(3, 8'h00);
      wr(0, 8'haf);
      lock_status <= 1'b1;
      repeat (6) @(posedge clk);
      rd(0, 8'h2f);
      rd(1, 8'h00);
      wr(1, 8'h20);
      // Register bit lands one edge after the strobe, the output flop one more
      repeat (2) @(negedge clk);
      chk(manual_track, 1);
      wr(1, 8'ha0);
      repeat (2) @(negedge clk);
      chk(auto_bandwidth, 1);
      rd(1, 8'hc0);
      $display("test reset and modes done");
      wr(0, 8'ha0);
      rd(0, 8'haf);
      lock_status <= 1'b0;
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk(pll_cpu_interrupt, 1);
      break_state <= 1'b1;
      rd(0, 8'hef);
      break_state <= 1'b0;
      rd(0, 8'hef);
      rd(0, 8'haf);
      lock_status <= 1'b1;
      repeat (7) @(posedge clk);
      break_state             <= 1'b1;
      break_flag_clear_enable <= 1'b1;
      rd(0, 8'hef);
      rd(0, 8'haf);
      break_state             <= 1'b0;
      break_flag_clear_enable <= 1'b0;
      lock_status <= 1'b0;
      repeat (7) @(posedge clk);
      rd(0, 8'hef);
      rd(0, 8'haf);
      repeat (2) @(negedge clk);
      chk(pll_cpu_interrupt, 0);
      $display("test lock flag done");
      wr(2, 8'h0a);
      rd(2, 8'h66);
      wr(0, 8'h00);
      rd(0, 8'h0f);
      wr(2, 8'h0a);
      rd(2, 8'h0a);
      @(negedge clk);
      chk(feedback_multiplier, 1);
      wr(2, 8'h60);
      wr(0, 8'h30);
      rd(0, 8'h2f);
      @(negedge clk);
      chk(pll_enable, 0);
      chk(vco_range_multiplier, 0);
      wr(0, 8'h00);
      wr(2, 8'h66);
      wr(0, 8'h30);
      rd(0, 8'h2f);
      wr(0, 8'h30);
      // Select lands, switch freezes, then the status flop follows
      repeat (3) @(negedge clk);
      chk(clock_switching, 1);
      hold = base_clock_out;
      n = 0;
      // Output must stay frozen for the whole source change
      while (clock_switching === 1'b1 && n < 200) begin
         @(negedge clk);
         chk(base_clock_out, hold);
         n++;
      end
      chk(clock_switching, 0);
      wr(0, 8'h10);
      rd(0, 8'h3f);
      $display("test clock select done");
      xtal_run <= 1'b0;
      wr(1, 8'h90);
      repeat (8) @(posedge clk);
      rd(1, 8'h90);
      xtal_run <= 1'b1;
      repeat (20) @(posedge clk);
      rd(1, 8'h80);
      @(posedge clk);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      rd(0, 8'h2f);
      rd(1, 8'h80);
      $display("test crystal loss and stop done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         track_status <= seed[8];
         wr(3, seed[7:0]);
         rd(1, 8'h80 | {2'h0, seed[8], 5'h00});
         rd(0, 8'h2f);
         rd(2, 8'h66);
      end
      $display("test random unmapped writes done");
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : testbench
`default_nettype wire
